// ===== pmg_pkg.sv
// Shared constants and types for the microphone mode and gain block
package pmg_pkg;
    localparam int          ADDR_W          = 12;
    // Register byte offsets
    localparam logic [11:0] OFS_INTEN_SET   = 12'h304;
    localparam logic [11:0] OFS_INTEN_CLR   = 12'h308;
    localparam logic [11:0] OFS_ENABLE      = 12'h500;
    localparam logic [11:0] OFS_CLK_RATE    = 12'h504;
    localparam logic [11:0] OFS_MODE        = 12'h508;
    localparam logic [11:0] OFS_GAIN_L      = 12'h518;
    localparam logic [11:0] OFS_GAIN_R      = 12'h51c;
    localparam logic [11:0] OFS_SAMPLE_PTR  = 12'h560;
    localparam logic [11:0] OFS_MAX_WORDS   = 12'h564;
    localparam logic [11:0] OFS_IRQ_STATUS  = 12'h600;
    // Event bit positions, shared by enable, status and clear registers
    localparam int          EV_STARTED      = 0;
    localparam int          EV_STOPPED      = 1;
    localparam int          EV_END          = 2;
    localparam int          EV_W            = 3;
    // Field widths and reset values
    localparam int          TRIM_W          = 7;
    localparam int          RATE_W          = 8;
    localparam int          CNT_W           = 15;
    localparam logic [6:0]  LOWEST_TRIM     = 7'h00;
    localparam logic [6:0]  NEUTRAL_TRIM    = 7'h28;
    localparam logic [6:0]  HIGHEST_TRIM    = 7'h50;
    localparam logic [7:0]  CLK_HALF_RESET  = 8'h30;
    localparam int          DECIM_DEFAULT   = 64;
    // Gain arithmetic: 0.5 dB is treated as 1/12 of an octave
    localparam logic [7:0]  TRIM_BIAS       = 8'h08;
    localparam logic [7:0]  STEPS_PER_OCT   = 8'h0c;
    localparam int          GAIN_SHIFT      = 18;
    localparam int          SAMPLE_W        = 16;

    typedef struct packed {
        logic left_on_rising;
        logic mono;
    } pmg_mode_t;

    typedef struct packed {
        logic signed [15:0] right;
        logic signed [15:0] left;
    } pmg_pair_t;
endpackage

// ===== pmg_gain_trim.sv
// Half-decibel gain trim applied to one channel of samples
module pmg_gain_trim import pmg_pkg::*; #(
    parameter int W = SAMPLE_W
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst,
    // Trim code and sample in
    input  wire logic [TRIM_W-1:0]   code,
    input  wire logic                in_valid,
    input  wire logic signed [W-1:0] in_sample,
    // Sample out
    output logic                     out_valid,
    output logic signed [W-1:0]      out_sample
);
    logic [TRIM_W-1:0]   eff_code;
    logic [7:0]          oct_index;
    logic [2:0]          octave;
    logic [3:0]          step;
    logic signed [39:0]  product;
    logic signed [39:0]  scaled;

    function automatic logic [15:0] step_factor(input logic [3:0] s);
        case (s)
            4'h0:    step_factor = 16'h4000;
            4'h1:    step_factor = 16'h43ce;
            4'h2:    step_factor = 16'h47d6;
            4'h3:    step_factor = 16'h4c1c;
            4'h4:    step_factor = 16'h50a3;
            4'h5:    step_factor = 16'h556e;
            4'h6:    step_factor = 16'h5a82;
            4'h7:    step_factor = 16'h5fe4;
            4'h8:    step_factor = 16'h6598;
            4'h9:    step_factor = 16'h6ba2;
            4'ha:    step_factor = 16'h7209;
            default: step_factor = 16'h78d1;
        endcase
    endfunction

    // Out-of-range codes act as the top code so scaling stays defined
    assign eff_code  = (code > HIGHEST_TRIM) ? HIGHEST_TRIM : code;
    // Neutral code maps to octave 4, step 0: a factor of exactly one
    assign oct_index = 8'(eff_code) + TRIM_BIAS;
    assign octave    = 3'(oct_index / STEPS_PER_OCT);
    assign step      = 4'(oct_index % STEPS_PER_OCT);
    assign product   = 40'(in_sample * $signed({1'b0, step_factor(step)}));
    assign scaled    = (product <<< octave) >>> GAIN_SHIFT;

    always_ff @(posedge mclk) begin
        if (rst) begin
            out_valid  <= 1'b0;
            out_sample <= '0;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                // Saturate rather than wrap at +20 dB
                if (scaled > 40'sd32767)
                    out_sample <= 16'h7fff;
                else if (scaled < -40'sd32768)
                    out_sample <= 16'h8000;
                else
                    out_sample <= W'(scaled);
            end
        end
    end

    a_trim_clamp: assert property (@(posedge mclk) disable iff (rst)
        (code > HIGHEST_TRIM) |-> (eff_code == HIGHEST_TRIM))
        else $error("trim code above top not clamped");

    a_neutral_unity: assert property (@(posedge mclk) disable iff (rst)
        (in_valid && code == NEUTRAL_TRIM) |=> (out_sample == $past(in_sample)))
        else $error("neutral trim changed the sample");
endmodule

// ===== pmg_mic_rx.sv
// Microphone receiver: APB registers, bit clock, capture, trim, packing, interrupt
// Operation
// - Clear-register one disables end interrupt
// - Stereo word: right high, left low
// - Mono word: earlier left low, later high
// - Edge field picks left sampling clock edge
// - Left trim steps half decibels, -20..+20
// - Left trim resets to neutral 0x28
// - Right trim uses same encoding, neutral reset
// - Words written to RAM from pointer
//
// The implementer's own choice: the APB interface to the registers.
module pmg_mic_rx import pmg_pkg::*; #(
    parameter int DECIM = DECIM_DEFAULT
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Microphone link
    output logic                   mic_bit_clock,
    input  wire logic              mic_data,
    // Sample RAM write port
    output logic                   ram_we,
    output logic      [31:0]       ram_addr,
    output logic      [31:0]       ram_wdata,
    // Interrupt
    output logic                   irq
);
    localparam int AW = $clog2(DECIM) + 1;
    localparam int SH = 15 - $clog2(DECIM);

    logic                  unit_enable;
    logic [RATE_W-1:0]     clk_half;
    pmg_mode_t             mode;
    logic [TRIM_W-1:0]     left_gain_code;
    logic [TRIM_W-1:0]     right_gain_code;
    logic [EV_W-1:0]       inten;
    logic [EV_W-1:0]       status;
    logic [31:0]           sample_ptr;
    logic [CNT_W-1:0]      max_words;

    logic                  wr_go;
    logic                  rd_go;
    logic [EV_W-1:0]       events;
    logic                  enable_d;

    logic [RATE_W-1:0]     div_cnt;
    logic                  edge_rise;
    logic                  edge_fall;
    logic                  data_s1;
    logic                  data_s2;
    logic [1:0]            take;
    logic [AW-1:0]         acc [2];
    logic [AW-2:0]         bit_cnt;
    logic                  period_end;
    logic                  raw_valid;
    logic signed [15:0]    raw [2];
    logic [TRIM_W-1:0]     codes [2];
    logic [1:0]            trim_valid;
    logic signed [15:0]    trimmed [2];

    pmg_pair_t             next_word;
    logic                  word_go;
    logic                  half_full;
    logic [15:0]           low_half;
    logic [CNT_W-1:0]      word_idx;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_INTEN_SET, OFS_INTEN_CLR, OFS_ENABLE, OFS_CLK_RATE, OFS_MODE,
            OFS_GAIN_L, OFS_GAIN_R, OFS_SAMPLE_PTR, OFS_MAX_WORDS,
            OFS_IRQ_STATUS: is_mapped = 1'b1;
            default:        is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic signed [15:0] to_pcm(input logic [AW-1:0] ones);
        logic signed [16:0] centred;
        centred = $signed(17'(ones)) - $signed(17'(DECIM / 2));
        to_pcm = 16'(centred <<< SH);
    endfunction

    // One wait state: pready rises the cycle after the access phase begins
    assign wr_go = psel && penable && pready && pwrite;
    assign rd_go = psel && penable && !pready && !pwrite;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !is_mapped(paddr);
            if (rd_go) begin
                case (paddr)
                    OFS_INTEN_SET,
                    OFS_INTEN_CLR:  prdata <= 32'(inten);
                    OFS_ENABLE:     prdata <= 32'(unit_enable);
                    OFS_CLK_RATE:   prdata <= 32'(clk_half);
                    OFS_MODE:       prdata <= 32'(mode);
                    OFS_GAIN_L:     prdata <= 32'(left_gain_code);
                    OFS_GAIN_R:     prdata <= 32'(right_gain_code);
                    OFS_SAMPLE_PTR: prdata <= sample_ptr;
                    OFS_MAX_WORDS:  prdata <= 32'(max_words);
                    OFS_IRQ_STATUS: prdata <= 32'(status);
                    default:        prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            unit_enable     <= 1'b0;
            clk_half        <= CLK_HALF_RESET;
            mode            <= '0;
            left_gain_code  <= NEUTRAL_TRIM;
            right_gain_code <= NEUTRAL_TRIM;
            sample_ptr      <= '0;
            max_words       <= '0;
        end else if (wr_go) begin
            case (paddr)
                OFS_ENABLE:     unit_enable     <= pwdata[0];
                OFS_CLK_RATE:   clk_half        <= pwdata[RATE_W-1:0];
                OFS_MODE:       mode            <= pwdata[1:0];
                OFS_GAIN_L:     left_gain_code  <= pwdata[TRIM_W-1:0];
                OFS_GAIN_R:     right_gain_code <= pwdata[TRIM_W-1:0];
                OFS_SAMPLE_PTR: sample_ptr      <= pwdata;
                OFS_MAX_WORDS:  max_words       <= pwdata[CNT_W-1:0];
                default:        ;
            endcase
        end
    end

    // Interrupt enables: set and clear registers, writing zero does nothing
    always_ff @(posedge mclk) begin
        if (rst)
            inten <= '0;
        else if (wr_go && paddr == OFS_INTEN_SET)
            inten <= inten | pwdata[EV_W-1:0];
        else if (wr_go && paddr == OFS_INTEN_CLR)
            inten <= inten & ~pwdata[EV_W-1:0];
    end

    // A new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            status   <= '0;
            enable_d <= 1'b0;
            irq      <= 1'b0;
        end else begin
            enable_d <= unit_enable;
            if (wr_go && paddr == OFS_IRQ_STATUS)
                status <= (status & ~pwdata[EV_W-1:0]) | events;
            else
                status <= status | events;
            irq <= |(status & inten);
        end
    end

    assign events[EV_STARTED] = unit_enable && !enable_d;
    assign events[EV_STOPPED] = !unit_enable && enable_d;
    assign events[EV_END]     = word_go && (word_idx + 1'b1 == max_words);

    // Bit clock is made here, so its edges are known without sampling it
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_cnt       <= '0;
            mic_bit_clock <= 1'b0;
            edge_rise     <= 1'b0;
            edge_fall     <= 1'b0;
        end else begin
            edge_rise <= 1'b0;
            edge_fall <= 1'b0;
            if (!unit_enable) begin
                div_cnt       <= '0;
                mic_bit_clock <= 1'b0;
            end else if (div_cnt >= clk_half) begin
                div_cnt       <= '0;
                mic_bit_clock <= !mic_bit_clock;
                edge_rise     <= !mic_bit_clock;
                edge_fall     <= mic_bit_clock;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    // Two-stage synchroniser; stage two lags the pin, so it still holds the
    // bit from just before the edge the divider flags
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_s1 <= 1'b0;
            data_s2 <= 1'b0;
        end else begin
            data_s1 <= mic_data;
            data_s2 <= data_s1;
        end
    end

    assign take[0] = mode.left_on_rising ? edge_rise : edge_fall;
    assign take[1] = mode.left_on_rising ? edge_fall : edge_rise;
    assign period_end = take[1] && (bit_cnt == (AW-1)'(DECIM - 1));

    // Stand-in decimation: count ones over DECIM bit periods per channel
    always_ff @(posedge mclk) begin
        if (rst || !unit_enable) begin
            acc[0]    <= '0;
            acc[1]    <= '0;
            bit_cnt   <= '0;
            raw_valid <= 1'b0;
            raw[0]    <= '0;
            raw[1]    <= '0;
        end else begin
            raw_valid <= period_end;
            if (take[0])
                acc[0] <= acc[0] + AW'(data_s2);
            if (period_end) begin
                raw[0]  <= to_pcm(acc[0]);
                raw[1]  <= to_pcm(acc[1] + AW'(data_s2));
                acc[1]  <= '0;
                acc[0]  <= '0;
                bit_cnt <= '0;
            end else if (take[1]) begin
                acc[1]  <= acc[1] + AW'(data_s2);
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    assign codes[0] = left_gain_code;
    assign codes[1] = right_gain_code;

    for (genvar ch = 0; ch < 2; ch++) begin : g_trim
        pmg_gain_trim #(
            .W          (SAMPLE_W)
        ) u_trim (
            .mclk       (mclk),
            .rst        (rst),
            .code       (codes[ch]),
            .in_valid   (raw_valid),
            .in_sample  (raw[ch]),
            .out_valid  (trim_valid[ch]),
            .out_sample (trimmed[ch])
        );
    end

    always_comb begin
        if (mode.mono) begin
            next_word.right = trimmed[0];
            next_word.left  = low_half;
        end else begin
            next_word.right = trimmed[1];
            next_word.left  = trimmed[0];
        end
    end

    // Mono fills the word in two passes; stereo writes every pass
    assign word_go = trim_valid[0] && unit_enable && (!mode.mono || half_full);

    always_ff @(posedge mclk) begin
        if (rst || !unit_enable) begin
            half_full <= 1'b0;
            low_half  <= '0;
        end else if (trim_valid[0] && mode.mono) begin
            half_full <= !half_full;
            if (!half_full)
                low_half <= trimmed[0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ram_we    <= 1'b0;
            ram_addr  <= '0;
            ram_wdata <= '0;
            word_idx  <= '0;
        end else begin
            ram_we <= word_go;
            if (!unit_enable) begin
                word_idx <= '0;
            end else if (word_go) begin
                ram_addr  <= sample_ptr + {15'h0000, word_idx, 2'b00};
                ram_wdata <= next_word;
                word_idx  <= events[EV_END] ? '0 : word_idx + 1'b1;
            end
        end
    end

    sequence s_clr_end;
        wr_go && paddr == OFS_INTEN_CLR && pwdata[EV_END];
    endsequence

    sequence s_first_mono;
        trim_valid[0] && unit_enable && mode.mono && !half_full;
    endsequence

    a_clr_disables: assert property (@(posedge mclk) disable iff (rst)
        s_clr_end |=> !inten[EV_END])
        else $error("clear write left end interrupt enabled");

    a_clr_zero_keeps: assert property (@(posedge mclk) disable iff (rst)
        (wr_go && paddr == OFS_INTEN_CLR && pwdata[EV_W-1:0] == '0) |=> $stable(inten))
        else $error("writing zero to clear changed enables");

    a_stereo_pack: assert property (@(posedge mclk) disable iff (rst)
        (word_go && !mode.mono) |=> (ram_we && ram_wdata == {$past(trimmed[1]), $past(trimmed[0])}))
        else $error("stereo word packed wrong");

    a_mono_pack: assert property (@(posedge mclk) disable iff (rst)
        s_first_mono ##1 (!trim_valid[0] && mode.mono)[*8] ##[1:600] (word_go && mode.mono)
        |=> (ram_wdata[15:0] == $past(low_half) && ram_wdata[31:16] == $past(trimmed[0])))
        else $error("mono word halves in wrong order");

    a_edge_select: assert property (@(posedge mclk) disable iff (rst)
        take[0] |-> (mode.left_on_rising ? $rose(mic_bit_clock) : $fell(mic_bit_clock)))
        else $error("left sampled on wrong clock edge");

    a_trim_reset: assert property (@(posedge mclk)
        $fell(rst) |-> (left_gain_code == NEUTRAL_TRIM && right_gain_code == NEUTRAL_TRIM))
        else $error("trim codes not neutral after reset");

    a_ram_first_addr: assert property (@(posedge mclk) disable iff (rst)
        (word_go && word_idx == '0) |=> (ram_we && ram_addr == $past(sample_ptr)))
        else $error("first word not at sample pointer");

    a_irq_level: assert property (@(posedge mclk) disable iff (rst)
        ##1 (irq == $past(|(status & inten))))
        else $error("interrupt does not follow masked status");

    a_apb_answer: assert property (@(posedge mclk) disable iff (rst)
        (psel && penable && !pready) |=> pready)
        else $error("APB access not answered in one wait state");
endmodule

// ===== pmg_mic_model.sv
// Behavioural pulse-density microphone pair sharing one data line
module pmg_mic_model (
    // Clocks
    input  wire logic       mclk,
    input  wire logic       mic_bit_clock,
    // Pattern per clock phase: 0 zeros, 1 ones, 2 three ones in four
    input  wire logic [1:0] hi_mode,
    input  wire logic [1:0] lo_mode,
    // Data line
    output wire logic       mic_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       last_clk = 1'b0;
    logic [7:0] idle     = 8'h00;
    logic [1:0] phase    = 2'h0;
    // Line starts at a known level so no unknown reaches the receiver
    logic       drive    = 1'b0;

    assign mic_data = drive;

    function automatic logic level(input logic [1:0] m, input logic [1:0] p);
        return (m == 2'd1) || (m == 2'd2 && p != 2'd0);
    endfunction

    // One mic drives after each rising edge, the other after each falling edge
    always @(posedge mclk) begin
        last_clk <= mic_bit_clock;
        if (last_clk !== mic_bit_clock) begin
            idle <= 8'h00;
            if (mic_bit_clock) begin
                phase <= phase + 2'd1;
                drive <= level(hi_mode, phase);
            end else begin
                drive <= level(lo_mode, phase);
            end
        end else begin
            if (idle != 8'hff) idle <= idle + 8'h01;
            // Stopped clock: line toggles every cycle once idle passes 0x40, so no stale value may pass for data
            if (idle > 8'h40) drive <= ~drive;
        end
    end
endmodule

// ===== test_pmg_mic_rx.sv
// Self-checking bench for the microphone mode and gain block
module test_pmg_mic_rx import pmg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, ram_addr, ram_wdata;
    logic        pready, pslverr, mic_bit_clock, mic_data, ram_we, irq;
    logic [1:0]  hi_mode = 2'd0, lo_mode = 2'd0;
    int          miscompares = 0;
    int          checks = 0;
    localparam logic [31:0] PTR = 32'h2000_0100;

    pmg_mic_rx #(.DECIM(8)) DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mic_bit_clock(mic_bit_clock), .mic_data(mic_data),
        .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .irq(irq));
    pmg_mic_model mics (.mclk(mclk), .mic_bit_clock(mic_bit_clock), .hi_mode(hi_mode),
        .lo_mode(lo_mode), .mic_data(mic_data));

    always #5 mclk = ~mclk;

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bail;
        miscompares++;
        $display("ERROR at %0t: wait timed out", $time);
        close_out();
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        int i;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) bail();
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    // Waits for n RAM words and returns the last one
    task automatic get_word(input int n, output logic [31:0] w, output logic [31:0] a);
        int i;
        for (int k = 0; k < n; k++) begin
            i = 0;
            do begin
                @(posedge mclk);
                i++;
            end while (ram_we !== 1'b1 && i < 3000);
            if (i >= 3000) bail();
        end
        w = ram_wdata;
        a = ram_addr;
    endtask

    function automatic logic [15:0] mag(input logic [15:0] v);
        return v[15] ? -v : v;
    endfunction

    task automatic t_reset_map;
        logic [31:0] r;
        logic        e;
        rd(OFS_MODE, r);       check(r, 32'h0);
        rd(OFS_GAIN_L, r);     check(r, 32'h28);
        rd(OFS_GAIN_R, r);     check(r, 32'h28);
        rd(OFS_INTEN_CLR, r);  check(r, 32'h0);
        check({31'h0, mic_bit_clock}, 32'h0);
        apb(1'b0, 12'h10c, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
    endtask

    task automatic t_enable_clear;
        logic [31:0] r;
        wr(OFS_INTEN_SET, 32'h4);
        rd(OFS_INTEN_CLR, r);  check(r, 32'h4);
        wr(OFS_INTEN_CLR, 32'h0);
        rd(OFS_INTEN_CLR, r);  check(r, 32'h4);
        wr(OFS_INTEN_CLR, 32'h4);
        rd(OFS_INTEN_CLR, r);  check(r, 32'h0);
    endtask

    task automatic t_ram_irq;
        logic [31:0] w, a, r;
        wr(OFS_SAMPLE_PTR, PTR);
        wr(OFS_MAX_WORDS, 32'h3);
        wr(OFS_CLK_RATE, 32'h7);
        wr(OFS_INTEN_SET, 32'h4);
        wr(OFS_ENABLE, 32'h1);
        for (int k = 0; k < 4; k++) begin
            get_word(1, w, a);
            check(a, PTR + 32'(4 * (k % 3)));
        end
        rd(OFS_IRQ_STATUS, r);
        check(r & 32'h4, 32'h4);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_STATUS, 32'h4);
        repeat (2) @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        // Mask end: status still latches but the line stays quiet
        wr(OFS_INTEN_CLR, 32'h4);
        get_word(3, w, a);
        rd(OFS_IRQ_STATUS, r);
        check(r & 32'h4, 32'h4);
        check({31'h0, irq}, 32'h0);
    endtask

    // Bit clock half period is the written half count plus one
    task automatic t_bit_clock;
        logic last;
        int   n;
        for (int k = 0; k < 2; k++) begin
            last = mic_bit_clock;
            n = 0;
            do begin
                @(posedge mclk);
                n++;
            end while (mic_bit_clock === last && n < 40);
            if (n >= 40) bail();
        end
        check(32'(n), 32'h8);
    endtask

    task automatic t_edge_pack;
        logic [31:0] w, a;
        @(posedge mclk);
        hi_mode <= 2'd1;
        lo_mode <= 2'd0;
        wr(OFS_MODE, 32'h0);
        get_word(3, w, a);
        check({w[31], w[15]}, 32'h2);
        wr(OFS_MODE, 32'h2);
        get_word(3, w, a);
        check({w[31], w[15]}, 32'h1);
    endtask

    task automatic t_mono;
        logic [31:0] w, a;
        @(posedge mclk);
        hi_mode <= 2'd0;
        lo_mode <= 2'd1;
        wr(OFS_MODE, 32'h1);
        get_word(3, w, a);
        check({w[31], w[15]}, 32'h3);
        // A rising input makes the earlier half never exceed the later
        @(posedge mclk);
        hi_mode <= 2'd1;
        for (int k = 0; k < 4; k++) begin
            get_word(1, w, a);
            check({31'h0, $signed(w[15:0]) <= $signed(w[31:16])}, 32'h1);
        end
    endtask

    task automatic t_gain;
        logic [31:0] w, a, r;
        logic [15:0] l0, r0, lh;
        logic [6:0]  codes [4] = '{7'h00, 7'h27, 7'h29, 7'h50};
        @(posedge mclk);
        hi_mode <= 2'd2;
        lo_mode <= 2'd2;
        wr(OFS_MODE, 32'h0);
        get_word(4, w, a);
        l0 = w[15:0];
        r0 = w[31:16];
        for (int k = 0; k < 4; k++) begin
            wr(OFS_GAIN_L, {25'h0, codes[k]});
            get_word(4, w, a);
            check({31'h0, (mag(w[15:0]) > mag(l0)) == (k > 1)}, 32'h1);
        end
        lh = w[15:0];
        wr(OFS_GAIN_L, 32'h7f);
        get_word(4, w, a);
        check({16'h0, w[15:0]}, {16'h0, lh});
        rd(OFS_GAIN_L, r);     check(r, 32'h7f);
        wr(OFS_GAIN_R, 32'h0);
        get_word(4, w, a);
        check({31'h0, mag(w[31:16]) < mag(r0)}, 32'h1);
        wr(OFS_GAIN_R, 32'h50);
        get_word(4, w, a);
        check({31'h0, mag(w[31:16]) > mag(r0)}, 32'h1);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_reset_map();
        t_enable_clear();
        t_ram_irq();
        t_bit_clock();
        t_edge_pack();
        t_mono();
        t_gain();
        close_out();
    end
endmodule
